// file: include/cfg_bank_map.svh
`ifndef CFG_BANK_MAP_SVH
`define CFG_BANK_MAP_SVH

`define REG_TRANSDUCER_KIND  8'h92
`define REG_PERMISSIVE_POL   8'h93
`define REG_SWITCH_ONE_POL   8'h94
`define REG_SWITCH_TWO_POL   8'h95
`define REG_CLOSURE_POL      8'h96
`define REG_SPARE_A_FIRST    8'h97
`define REG_SPARE_A_LAST     8'h9a
`define REG_ACCESS_CODE      8'h9b
`define REG_ACCESS_CODE_EN   8'h9c
`define REG_SPARE_B_FIRST    8'h9d
`define REG_SPARE_B_LAST     8'h9f
`define REG_SCREEN_DELAY     8'ha0

`define RST_TRANSDUCER_KIND  16'h0000
`define RST_PERMISSIVE_POL   16'h0001
`define RST_SWITCH_ONE_POL   16'h0000
`define RST_SWITCH_TWO_POL   16'h0000
`define RST_CLOSURE_POL      16'h0001
`define RST_ACCESS_CODE      16'h0000
`define RST_ACCESS_CODE_EN   16'h0000
`define RST_SCREEN_DELAY     16'h0708

`define TRANSDUCER_KIND_MAX  16'h0004
`define ACCESS_CODE_MAX      16'h270f
`define SCREEN_DELAY_MIN     16'h001e
`define SCREEN_DELAY_MAX     16'h0708

`define CLK_HZ               25000000
`define SPARE_READ_VALUE     16'h0000

`endif

// file: include/cfg_bank_pkg.sv
package cfg_bank_pkg;
	typedef struct packed {
		logic [15:0] transducer_kind_select;
		logic [15:0] permissive_input_polarity;
		logic [15:0] switch_one_polarity;
		logic [15:0] switch_two_polarity;
		logic [15:0] closure_proof_polarity;
		logic [15:0] menu_access_code;
		logic [15:0] menu_access_code_enable;
		logic [15:0] screen_off_delay;
		logic [15:0] rd_data;
	} bank_state_type;

	typedef struct packed {
		logic [24:0] tick_count;
		logic        tick;
	} tick_state_type;

	typedef enum logic {
		screen_dark,
		screen_lit
	} screen_mode_type;

	typedef struct packed {
		screen_mode_type mode;
		logic [15:0]     seconds_left;
	} screen_state_type;
endpackage

// file: hw/second_tick.sv
`timescale 1ns/1ps
`include "cfg_bank_map.svh"

module second_tick #(
	parameter int unsigned CYCLES_PER_SECOND = `CLK_HZ
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic restart,
	output logic      tick
);
	localparam logic [24:0] LAST = 25'(CYCLES_PER_SECOND - 1);

	cfg_bank_pkg::tick_state_type s_q;
	cfg_bank_pkg::tick_state_type s_d;

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (restart) begin
			s_d.tick_count = '0;
		end else if (s_q.tick_count == LAST) begin
			s_d.tick_count = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.tick_count = s_q.tick_count + 25'h0000001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
endmodule

// file: hw/config_register_bank.sv
`timescale 1ns/1ps
`include "cfg_bank_map.svh"

// What this block does
// [R1] Transducer kind: 0 fixed model, 1 mV/V, 2 ratio, 3 1-5V, 4 4-20mA.
// [R2] Transducer kind is a 16-bit read/write value, zero after reset.
// [R3] Permissive and closure-proof polarity: 1 closed, 0 open; reset to 1.
// [R4] Switch one polarity: 1 normally closed, 0 open; resets to 0.
// [R5] Switch two polarity: 1 normally closed, 0 open; resets to 0.
// [R6] Menu passcode holds 0000 to 9999, reset 0000, gates menus.
// [R7] Passcode enable 1 requires the passcode for menus; 0 does not; reset 0.
// [R8] Display timeout holds 30 to 1800 seconds, reset 1800.
// [R9] Display stays lit for timeout seconds after last menu interaction.
// [R10] Unused register numbers are read-only; writes to them are ignored.
module config_register_bank #(
	parameter int unsigned CYCLES_PER_SECOND = `CLK_HZ
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_wr_reject,
	input  wire logic        menu_activity,
	input  wire logic        switch_input_one,
	input  wire logic        switch_input_two,
	input  wire logic        permissive_input,
	input  wire logic        closure_proof_input,
	output logic             switch_one_active,
	output logic             switch_two_active,
	output logic             permissive_active,
	output logic             closure_proof_active,
	output logic      [2:0]  transducer_kind_select,
	output logic      [15:0] menu_access_code,
	output logic             menu_code_required,
	output logic             display_on
);
	cfg_bank_pkg::bank_state_type   b_q;
	cfg_bank_pkg::bank_state_type   b_d;
	cfg_bank_pkg::screen_state_type d_q;
	cfg_bank_pkg::screen_state_type d_d;
	logic                           sec_tick;
	logic                           value_ok;
	logic                           writable;

	second_tick #(
		.CYCLES_PER_SECOND(CYCLES_PER_SECOND)
	) u_tick (
		.clk    (clk),
		.rst    (rst),
		.restart(menu_activity),
		.tick   (sec_tick)
	);

	// Out-of-range writes are dropped whole rather than clipped, so
	// software sees at once that the old value still stands.
	always_comb begin
		writable = 1'b1;
		value_ok = 1'b1;
		unique case (reg_addr)
			`REG_TRANSDUCER_KIND:
				value_ok = reg_wdata <= `TRANSDUCER_KIND_MAX; // see [R1]
			`REG_PERMISSIVE_POL, `REG_CLOSURE_POL,
			`REG_SWITCH_ONE_POL, `REG_SWITCH_TWO_POL,
			`REG_ACCESS_CODE_EN:
				value_ok = reg_wdata[15:1] == 15'h0000;
			`REG_ACCESS_CODE:
				value_ok = reg_wdata <= `ACCESS_CODE_MAX; // see [R6]
			`REG_SCREEN_DELAY:
				value_ok = reg_wdata >= `SCREEN_DELAY_MIN &&
					reg_wdata <= `SCREEN_DELAY_MAX; // see [R8]
			default:
				writable = 1'b0; // see [R10]
		endcase
	end

	always_comb begin
		b_d = b_q;
		if (reg_wr && writable && value_ok) begin
			unique case (reg_addr)
				`REG_TRANSDUCER_KIND: begin
					b_d.transducer_kind_select = reg_wdata; // see [R2]
				end
				`REG_PERMISSIVE_POL: begin
					b_d.permissive_input_polarity = reg_wdata; // see [R3]
				end
				`REG_SWITCH_ONE_POL: begin
					b_d.switch_one_polarity = reg_wdata; // see [R4]
				end
				`REG_SWITCH_TWO_POL: begin
					b_d.switch_two_polarity = reg_wdata; // see [R5]
				end
				`REG_CLOSURE_POL: begin
					b_d.closure_proof_polarity = reg_wdata; // see [R3]
				end
				`REG_ACCESS_CODE: begin
					b_d.menu_access_code = reg_wdata; // see [R6]
				end
				`REG_ACCESS_CODE_EN: begin
					b_d.menu_access_code_enable = reg_wdata; // see [R7]
				end
				`REG_SCREEN_DELAY: begin
					b_d.screen_off_delay = reg_wdata; // see [R8]
				end
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				`REG_TRANSDUCER_KIND:
					b_d.rd_data = b_q.transducer_kind_select;
				`REG_PERMISSIVE_POL:
					b_d.rd_data = b_q.permissive_input_polarity;
				`REG_SWITCH_ONE_POL:
					b_d.rd_data = b_q.switch_one_polarity;
				`REG_SWITCH_TWO_POL:
					b_d.rd_data = b_q.switch_two_polarity;
				`REG_CLOSURE_POL:
					b_d.rd_data = b_q.closure_proof_polarity;
				`REG_ACCESS_CODE:
					b_d.rd_data = b_q.menu_access_code;
				`REG_ACCESS_CODE_EN:
					b_d.rd_data = b_q.menu_access_code_enable;
				`REG_SCREEN_DELAY:
					b_d.rd_data = b_q.screen_off_delay;
				default:
					b_d.rd_data = `SPARE_READ_VALUE; // see [R10]
			endcase
		end
	end

	// Timer restarts from the full programmed value on every menu touch;
	// a new timeout takes effect at the next interaction, not mid-count.
	always_comb begin
		d_d = d_q;
		if (menu_activity) begin
			d_d.mode = cfg_bank_pkg::screen_lit; // see [R9]
			d_d.seconds_left = b_q.screen_off_delay;
		end else begin
			unique case (d_q.mode)
				cfg_bank_pkg::screen_lit: begin
					if (sec_tick) begin
						d_d.seconds_left = d_q.seconds_left - 16'h0001;
						if (d_q.seconds_left == 16'h0001) begin
							d_d.mode = cfg_bank_pkg::screen_dark; // see [R9]
						end
					end
				end
				cfg_bank_pkg::screen_dark: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			b_q.transducer_kind_select    <= `RST_TRANSDUCER_KIND; // see [R2]
			b_q.permissive_input_polarity <= `RST_PERMISSIVE_POL; // see [R3]
			b_q.switch_one_polarity       <= `RST_SWITCH_ONE_POL; // see [R4]
			b_q.switch_two_polarity       <= `RST_SWITCH_TWO_POL; // see [R5]
			b_q.closure_proof_polarity    <= `RST_CLOSURE_POL; // see [R3]
			b_q.menu_access_code          <= `RST_ACCESS_CODE; // see [R6]
			b_q.menu_access_code_enable   <= `RST_ACCESS_CODE_EN; // see [R7]
			b_q.screen_off_delay          <= `RST_SCREEN_DELAY; // see [R8]
			b_q.rd_data                   <= 16'h0000;
			d_q.mode                      <= cfg_bank_pkg::screen_lit;
			d_q.seconds_left              <= `RST_SCREEN_DELAY;
		end else begin
			b_q <= b_d;
			d_q <= d_d;
		end
	end

	assign reg_rdata              = b_q.rd_data;
	assign reg_wr_reject          = reg_wr && !(writable && value_ok);
	// Polarity 1 means the contact is closed at rest, so open means active
	assign switch_one_active      = switch_input_one ^
		b_q.switch_one_polarity[0]; // see [R4]
	assign switch_two_active      = switch_input_two ^
		b_q.switch_two_polarity[0]; // see [R5]
	assign permissive_active      = permissive_input ^
		b_q.permissive_input_polarity[0]; // see [R3]
	assign closure_proof_active   = closure_proof_input ^
		b_q.closure_proof_polarity[0]; // see [R3]
	assign transducer_kind_select = b_q.transducer_kind_select[2:0]; // see [R1]
	assign menu_access_code       = b_q.menu_access_code;
	assign menu_code_required     = b_q.menu_access_code_enable[0]; // see [R7]
	assign display_on             = d_q.mode == cfg_bank_pkg::screen_lit;

	sequence touch_s;
		menu_activity;
	endsequence

	sequence lit_after_s;
		##1 display_on;
	endsequence

	kind_range_a: assert property (@(posedge clk) disable iff (rst) // see [R1]
		b_q.transducer_kind_select <= `TRANSDUCER_KIND_MAX)
		else $error("transducer kind out of range");
	kind_write_a: assert property (@(posedge clk) disable iff (rst) // see [R2]
		reg_wr && reg_addr == `REG_TRANSDUCER_KIND &&
		reg_wdata <= `TRANSDUCER_KIND_MAX |=>
		b_q.transducer_kind_select == $past(reg_wdata))
		else $error("transducer kind write lost");
	closure_act_a: assert property (@(posedge clk) disable iff (rst) // see [R3]
		b_q.closure_proof_polarity[0] |->
		closure_proof_active == !closure_proof_input)
		else $error("closure proof polarity wrong");
	switch_one_a: assert property (@(posedge clk) disable iff (rst) // see [R4]
		!b_q.switch_one_polarity[0] |->
		switch_one_active == switch_input_one)
		else $error("switch one polarity wrong");
	switch_two_a: assert property (@(posedge clk) disable iff (rst) // see [R5]
		reg_wr && reg_addr == `REG_SWITCH_TWO_POL && reg_wdata == 16'h0001
		|=> ##0 switch_two_active == !switch_input_two)
		else $error("switch two polarity not applied");
	code_range_a: assert property (@(posedge clk) disable iff (rst) // see [R6]
		b_q.menu_access_code <= `ACCESS_CODE_MAX)
		else $error("passcode out of range");
	code_enable_a: assert property (@(posedge clk) disable iff (rst) // see [R7]
		reg_wr && reg_addr == `REG_ACCESS_CODE_EN && reg_wdata == 16'h0000
		|=> !menu_code_required)
		else $error("passcode enable not cleared");
	delay_range_a: assert property (@(posedge clk) disable iff (rst) // see [R8]
		b_q.screen_off_delay >= `SCREEN_DELAY_MIN &&
		b_q.screen_off_delay <= `SCREEN_DELAY_MAX)
		else $error("display timeout out of range");
	screen_wake_a: assert property (@(posedge clk) disable iff (rst) // see [R9]
		touch_s |-> lit_after_s)
		else $error("display not lit after menu activity");
	screen_dark_a: assert property (@(posedge clk) disable iff (rst) // see [R9]
		$fell(display_on) |-> $past(sec_tick) && !$past(menu_activity))
		else $error("display went dark without expiry");
	spare_write_a: assert property (@(posedge clk) disable iff (rst) // see [R10]
		reg_wr && reg_addr >= `REG_SPARE_B_FIRST &&
		reg_addr <= `REG_SPARE_B_LAST |=> $stable(b_q.screen_off_delay))
		else $error("spare write changed state");
endmodule

// file: dv/modbus_master_model.sv
`timescale 1ns/1ps
// Register master: one strobe cycle per access, then the bus is released
module modbus_master_model (
	input  wire logic        clk,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [7:0]  reg_addr,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_wr_reject
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
	end
	// Released address and data are inverted so stale values never match
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] rv, output logic rj);
		@(posedge clk);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(negedge clk);
		rj = reg_wr_reject;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		@(negedge clk);
		rv = reg_rdata;
	endtask
endmodule

// file: dv/config_register_bank_inputs_access_tb_top.sv
`timescale 1ns/1ps
module config_register_bank_inputs_access_tb_top;
	localparam int CPS = 4;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        menu_activity = 1'b0;
	logic [3:0]  in_v = 4'h0;
	logic        reg_wr, reg_rd, reg_wr_reject, code_req, display_on, rj;
	logic [7:0]  reg_addr, a;
	logic [15:0] reg_wdata, reg_rdata, code, rv, d;
	logic [3:0]  act;
	logic [2:0]  kind;
	logic [15:0] mdl [8'h90:8'ha2];
	int          err_count = 0;
	int          comparisons = 0;
	int          seed = 84;
	logic [7:0]  ca [12] = '{8'h92, 8'h92, 8'h9b, 8'h9b, 8'ha0, 8'ha0,
		8'ha0, 8'ha0, 8'h97, 8'h9f, 8'h93, 8'h9c};
	logic [15:0] cv [12] = '{16'h0004, 16'h0005, 16'h270f, 16'h2710,
		16'h001d, 16'h001e, 16'h0708, 16'h0709, 16'h0001, 16'h0000,
		16'h0002, 16'h0001};

	always #20 clk = ~clk;

	config_register_bank #(.CYCLES_PER_SECOND(CPS)) dut_u (
		.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_wr_reject(reg_wr_reject), .menu_activity(menu_activity),
		.switch_input_one(in_v[3]), .switch_input_two(in_v[2]),
		.permissive_input(in_v[1]), .closure_proof_input(in_v[0]),
		.switch_one_active(act[3]), .switch_two_active(act[2]),
		.permissive_active(act[1]), .closure_proof_active(act[0]),
		.transducer_kind_select(kind), .menu_access_code(code),
		.menu_code_required(code_req), .display_on(display_on));

	modbus_master_model mst_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_wr_reject(reg_wr_reject));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Out-of-range values are dropped, never clamped
	function automatic logic legal(input logic [7:0] x, input logic [15:0] v);
		case (x)
			8'h92: return v <= 16'h0004;
			8'h93, 8'h94, 8'h95, 8'h96, 8'h9c: return v <= 16'h0001;
			8'h9b: return v <= 16'h270f;
			8'ha0: return v >= 16'h001e && v <= 16'h0708;
			default: return 1'b0;
		endcase
	endfunction

	task automatic wr(input logic [7:0] x, input logic [15:0] v);
		mst_u.xfer(1'b1, x, v, rv, rj);
		check({15'h0, rj}, {15'h0, !legal(x, v)});
		if (legal(x, v)) mdl[x] = v;
	endtask

	task automatic rd(input logic [7:0] x);
		mst_u.xfer(1'b0, x, 16'h0000, rv, rj);
		check(rv, mdl[x]);
	endtask

	task automatic outs;
		logic [3:0] pol;
		@(posedge clk);
		in_v <= 4'($random(seed));
		@(negedge clk);
		pol = {mdl[8'h94][0], mdl[8'h95][0], mdl[8'h93][0], mdl[8'h96][0]};
		check({12'h0, act}, {12'h0, in_v ^ pol});
		check({13'h0, kind}, {13'h0, mdl[8'h92][2:0]});
		check(code, mdl[8'h9b]);
		check({15'h0, code_req}, {15'h0, mdl[8'h9c][0]});
	endtask

	task automatic do_reset;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (mdl[i]) mdl[i] = 16'h0000;
		mdl[8'h93] = 16'h0001;
		mdl[8'h96] = 16'h0001;
		mdl[8'ha0] = 16'h0708;
		for (int n = 8'h90; n <= 8'ha2; n++) rd(8'(n));
		outs;
	endtask

	task automatic pulse;
		@(posedge clk);
		menu_activity <= 1'b1;
		@(posedge clk);
		menu_activity <= 1'b0;
	endtask

	task automatic lit(input logic e, input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
		check({15'h0, display_on}, {15'h0, e});
	endtask

	initial begin
		do_reset;
		lit(1'b1, 0);
		repeat (80) begin
			a = 8'h90 + 8'($unsigned($random(seed)) % 19);
			case ($unsigned($random(seed)) % 4)
				0: d = 16'($random(seed)) & 16'h0007;
				1: d = 16'($random(seed)) & 16'h0001;
				2: d = 16'($random(seed)) & 16'h3fff;
				default: d = 16'($random(seed)) & 16'h07ff;
			endcase
			wr(a, d);
			rd(a);
			outs;
		end
		foreach (ca[i]) begin
			wr(ca[i], cv[i]);
			rd(ca[i]);
		end
		outs;
		// A 30 s delay at four cycles a second goes dark near cycle 121
		wr(8'ha0, 16'h001e);
		pulse;
		lit(1'b1, 0);
		lit(1'b1, 113);
		lit(1'b0, 12);
		pulse;
		lit(1'b1, 0);
		lit(1'b1, 60);
		pulse;
		lit(1'b1, 113);
		lit(1'b0, 12);
		do_reset;
		end_sim;
	end

	initial begin
		repeat (6000) @(posedge clk);
		err_count++;
		end_sim;
	end
endmodule
